// ---- core/media_object_payload_assembler.sv ----
// Work-item payload assembler: command parse, indirect fetch, row packing
//
// What this block does
// - Indirect fetch address is the base register plus the command's start address.
// - Without indirect data the start address is ignored and nothing is fetched.
// - Inverse-scan mode decodes the first inline dword by its field layout; bitstream mode keeps the whole dword.
// - Generic mode passes inline dwords into the payload untouched.
// - First inline dword is command dword 4.
// - Inline dword count is the length field minus two.
// - A non-multiple-of-eight inline count gives N/8+1 rows, zero filled.
// - A multiple-of-eight inline count gives exactly N/8 rows.
// - Indirect data starts on the row after the last inline row.
// - A short last indirect row is zero filled.
// - Indirect length zero disables the indirect fetch.
`timescale 1ns/10ps
`default_nettype none
module media_object_payload_assembler (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Register bus read
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Command dword stream
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [31:0] cmd_data,
  // Indirect fetch request and data
  output logic fetch_valid,
  input wire logic fetch_ready,
  output payload_pkg::fetch_req_t fetch_req,
  input wire logic fdat_valid,
  output logic fdat_ready,
  input wire logic [31:0] fdat_data,
  // Payload rows
  output logic pay_valid,
  input wire logic pay_ready,
  output payload_pkg::payload_row_t pay_row,
  output logic obj_done
);
  typedef struct packed {
    payload_pkg::phase_t st;
    logic [1:0] mode;
    logic [1:0] cur_mode;
    logic [31:0] base;
    logic [7:0] left;
    logic [7:0] n_inl;
    logic [payload_pkg::ILEN_W-1:0] ilen;
    logic [31:0] start;
    logic [15:0] fleft;
    logic [31:0] pend;
    logic pend_v;
    logic pend_last;
    logic first;
    logic cmd_ready;
    logic fetch_valid;
    logic fdat_ready;
    logic done;
    logic err_align;
    logic err_range;
    logic [31:0] decode;
    logic awready;
    logic wready;
    logic aw_v;
    logic w_v;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asm_t;

  asm_t s_reg;
  asm_t s_next;
  logic pk_ready;
  logic pk_idle;
  logic cmd_hs;
  logic fdat_hs;
  logic pushed;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == payload_pkg::REG_CTRL) || (a == payload_pkg::REG_BASE) ||
             (a == payload_pkg::REG_STATUS) || (a == payload_pkg::REG_DECODE);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
    merge = o;
    for (int i = 0; i < 4; i++)
    begin
      if (b[i])
      begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  assign cmd_hs = s_reg.cmd_ready && cmd_valid;
  assign fdat_hs = s_reg.fdat_ready && fdat_valid;
  assign pushed = s_reg.pend_v && pk_ready;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [31:0] rd;
    rd = '0;
    s_next = s_reg;
    s_next.done = 1'b0;
    // Register writes; error clears come first so a same-cycle set wins
    if (awvalid && s_reg.awready)
    begin
      s_next.awaddr = awaddr;
      s_next.aw_v = 1'b1;
      s_next.awready = 1'b0;
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
      s_next.w_v = 1'b1;
      s_next.wready = 1'b0;
    end
    if (s_reg.aw_v && s_reg.w_v && !s_reg.bvalid)
    begin
      s_next.aw_v = 1'b0;
      s_next.w_v = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? payload_pkg::RESP_OKAY : payload_pkg::RESP_SLVERR;
      case (s_reg.awaddr)
        payload_pkg::REG_CTRL:
          if (s_reg.wstrb[0])
          begin
            s_next.mode = s_reg.wdata[payload_pkg::CTRL_MODE_LSB +: 2];
          end
        payload_pkg::REG_BASE:
          s_next.base = merge(s_reg.base, s_reg.wdata, s_reg.wstrb);
        payload_pkg::REG_STATUS:
          if (s_reg.wstrb[0])
          begin
            if (s_reg.wdata[payload_pkg::STAT_ALIGN_BIT])
            begin
              s_next.err_align = 1'b0;
            end
            if (s_reg.wdata[payload_pkg::STAT_RANGE_BIT])
            begin
              s_next.err_range = 1'b0;
            end
          end
        default:
          s_next.bresp = s_next.bresp;
      endcase
    end
    if (s_reg.bvalid && bready)
    begin
      s_next.bvalid = 1'b0;
    end
    // Register reads
    if (arvalid && s_reg.arready)
    begin
      case (araddr)
        payload_pkg::REG_CTRL: rd[payload_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
        payload_pkg::REG_BASE: rd = s_reg.base;
        payload_pkg::REG_STATUS:
        begin
          rd[payload_pkg::STAT_BUSY_BIT] = (s_reg.st != payload_pkg::S_HDR);
          rd[payload_pkg::STAT_ALIGN_BIT] = s_reg.err_align;
          rd[payload_pkg::STAT_RANGE_BIT] = s_reg.err_range;
          rd[payload_pkg::STAT_ROWS_LSB +: payload_pkg::ROW_IDX_W] = pay_row.idx;
        end
        payload_pkg::REG_DECODE: rd = s_reg.decode;
        default: rd = '0;
      endcase
      s_next.rdata = rd;
      s_next.rresp = mapped(araddr) ? payload_pkg::RESP_OKAY : payload_pkg::RESP_SLVERR;
      s_next.rvalid = 1'b1;
      s_next.arready = 1'b0;
    end
    if (s_reg.rvalid && rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Command walk
    if (pushed)
    begin
      s_next.pend_v = 1'b0;
    end
    case (s_reg.st)
      payload_pkg::S_HDR:
        if (cmd_hs)
        begin
          s_next.left = cmd_data[payload_pkg::HDR_LEN_LSB +: 8] - payload_pkg::HDR_EXTRA_DW;
          s_next.n_inl = cmd_data[payload_pkg::HDR_LEN_LSB +: 8] - payload_pkg::HDR_EXTRA_DW;
          s_next.cur_mode = s_reg.mode;
          s_next.first = 1'b1;
          s_next.st = payload_pkg::S_DESC;
        end
      payload_pkg::S_DESC:
        if (cmd_hs)
        begin
          s_next.st = payload_pkg::S_ILEN;
        end
      payload_pkg::S_ILEN:
        if (cmd_hs)
        begin
          s_next.ilen = cmd_data[payload_pkg::ILEN_W-1:0];
          s_next.st = payload_pkg::S_ADDR;
        end
      payload_pkg::S_ADDR:
        if (cmd_hs)
        begin
          s_next.start = cmd_data;
          // Misaligned pointers outside bitstream mode and out-of-range pointers are flagged, not refused
          if (s_reg.ilen != '0)
          begin
            if (s_reg.cur_mode != payload_pkg::MODE_BITSTREAM && cmd_data[1:0] != 2'h0)
            begin
              s_next.err_align = 1'b1;
            end
            if (cmd_data[31:payload_pkg::ADDR_TOP_LSB] != 3'h0)
            begin
              s_next.err_range = 1'b1;
            end
          end
          if (s_reg.left != 8'h00)
          begin
            s_next.st = payload_pkg::S_INL;
          end
          else
          begin
            s_next.cmd_ready = 1'b0;
            if (s_reg.ilen != '0)
            begin
              s_next.st = payload_pkg::S_FREQ;
              s_next.fetch_valid = 1'b1;
            end
            else
            begin
              s_next.st = payload_pkg::S_FLUSH;
            end
          end
        end
      payload_pkg::S_INL:
      begin
        if (cmd_hs)
        begin
          s_next.pend = cmd_data;
          s_next.pend_v = 1'b1;
          s_next.pend_last = (s_reg.left == 8'h01);
          s_next.left = s_reg.left - 8'h01;
          s_next.first = 1'b0;
          if (s_reg.first && s_reg.cur_mode == payload_pkg::MODE_INV_SCAN)
          begin
            s_next.decode = {24'h000000, cmd_data[31:payload_pkg::IS_FIELD_LSB]};
          end
          else if (s_reg.first && s_reg.cur_mode == payload_pkg::MODE_BITSTREAM)
          begin
            s_next.decode = cmd_data;
          end
        end
        if (pushed && s_reg.pend_last)
        begin
          // Indirect words wait behind the last inline row in the packer
          if (s_reg.ilen != '0)
          begin
            s_next.st = payload_pkg::S_FREQ;
            s_next.fetch_valid = 1'b1;
          end
          else
          begin
            s_next.st = payload_pkg::S_FLUSH;
          end
        end
        s_next.cmd_ready = !s_next.pend_v && (s_next.left != 8'h00);
      end
      payload_pkg::S_FREQ:
        if (s_reg.fetch_valid && fetch_ready)
        begin
          s_next.fetch_valid = 1'b0;
          s_next.fleft = 16'(({1'b0, s_reg.ilen} + payload_pkg::DW_ROUND) >> 2);
          s_next.fdat_ready = 1'b1;
          s_next.st = payload_pkg::S_FDAT;
        end
      payload_pkg::S_FDAT:
      begin
        if (fdat_hs)
        begin
          s_next.pend = fdat_data;
          s_next.pend_v = 1'b1;
          s_next.pend_last = (s_reg.fleft == 16'h0001);
          s_next.fleft = s_reg.fleft - 16'h0001;
        end
        if (pushed && s_reg.pend_last)
        begin
          s_next.st = payload_pkg::S_FLUSH;
        end
        s_next.fdat_ready = !s_next.pend_v && (s_next.fleft != 16'h0000);
      end
      payload_pkg::S_FLUSH:
        if (pk_idle)
        begin
          s_next.done = 1'b1;
          s_next.cmd_ready = 1'b1;
          s_next.st = payload_pkg::S_HDR;
        end
      default:
        s_next.st = payload_pkg::S_HDR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.st <= payload_pkg::S_HDR;
      s_reg.mode <= payload_pkg::CTRL_MODE_RST;
      s_reg.base <= payload_pkg::BASE_RST;
      s_reg.cmd_ready <= 1'b1;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  row_packer u_pack (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(s_reg.pend_v),
    .in_data(s_reg.pend),
    .in_last(s_reg.pend_last),
    .in_ready(pk_ready),
    .clr(cmd_hs && s_reg.st == payload_pkg::S_HDR),
    .out_valid(pay_valid),
    .out_row(pay_row),
    .out_ready(pay_ready),
    .idle(pk_idle)
  );

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign cmd_ready = s_reg.cmd_ready;
  assign fetch_valid = s_reg.fetch_valid;
  assign fetch_req = {s_reg.base + s_reg.start, s_reg.ilen};
  assign fdat_ready = s_reg.fdat_ready;
  assign obj_done = s_reg.done;

  ////////////////////////////////////////////////////////////////////////////
  // Expected row total: inline and indirect each rounded up to whole rows
  logic [15:0] ind_dw;
  logic [15:0] exp_rows;
  assign ind_dw = 16'(({1'b0, s_reg.ilen} + payload_pkg::DW_ROUND) >> 2);
  assign exp_rows = 16'(({8'h00, s_reg.n_inl} + 16'h0007) >> 3) + 16'((ind_dw + 16'h0007) >> 3);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_addr;
    $rose(s_reg.fetch_valid) |-> fetch_req.addr == s_reg.base + s_reg.start;
  endproperty
  a_addr: assert property (p_addr)
    else $error("fetch address is not base plus start");
  property p_nofetch;
    s_reg.fetch_valid |-> s_reg.ilen != '0 && s_reg.st == payload_pkg::S_FREQ;
  endproperty
  a_nofetch: assert property (p_nofetch)
    else $error("fetch issued without indirect length");
  property p_count;
    (s_reg.st == payload_pkg::S_HDR && cmd_hs) |=> s_reg.left == $past(cmd_data[7:0]) - 8'h02;
  endproperty
  a_count: assert property (p_count)
    else $error("inline count not length minus two");
  property p_first;
    (s_reg.st == payload_pkg::S_ADDR && cmd_hs && s_reg.left != 8'h00) ##1 cmd_hs |=>
      s_reg.pend_v && s_reg.pend == $past(cmd_data);
  endproperty
  a_first: assert property (p_first)
    else $error("dword 4 not taken as first inline dword");
  property p_rows;
    s_reg.done |-> 16'(pay_row.idx) == exp_rows;
  endproperty
  a_rows: assert property (p_rows)
    else $error("payload row total wrong");
  property p_order;
    (pay_valid && pay_ready) |=> pay_row.idx == $past(pay_row.idx) + 6'h01;
  endproperty
  a_order: assert property (p_order)
    else $error("payload rows not ascending");
  property p_decode;
    (s_reg.st == payload_pkg::S_INL && cmd_hs && s_reg.first &&
     s_reg.cur_mode == payload_pkg::MODE_INV_SCAN) |=> s_reg.decode[7:0] == $past(cmd_data[31:24]);
  endproperty
  a_decode: assert property (p_decode)
    else $error("inverse-scan fields not decoded");
  property p_opaque;
    (s_reg.st == payload_pkg::S_INL && cmd_hs && s_reg.cur_mode == payload_pkg::MODE_GENERIC)
      |=> $stable(s_reg.decode) && s_reg.pend == $past(cmd_data);
  endproperty
  a_opaque: assert property (p_opaque)
    else $error("generic inline data interpreted or altered");

  c_fetch: cover property (s_reg.st == payload_pkg::S_FDAT && pushed && s_reg.pend_last);
  c_inline_only: cover property (s_reg.done && s_reg.ilen == '0);
  c_write: cover property (s_reg.bvalid && bready);
endmodule
`default_nettype wire

// ---- core/payload_pkg.sv ----
// Shared constants, types and register map for the payload assembler
package payload_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_BASE = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_DECODE = 12'h00c;
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ALIGN_BIT = 1;
  localparam int STAT_RANGE_BIT = 2;
  localparam int STAT_ROWS_LSB = 8;
  localparam int HDR_LEN_LSB = 0;
  localparam int ADDR_TOP_LSB = 29;
  localparam int IS_FIELD_LSB = 24;
  // Reset values
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  // Modes
  localparam logic [1:0] MODE_GENERIC = 2'h0;
  localparam logic [1:0] MODE_INV_SCAN = 2'h1;
  localparam logic [1:0] MODE_BITSTREAM = 2'h2;
  // Sizes
  localparam logic [7:0] HDR_EXTRA_DW = 8'h02;
  localparam logic [17:0] DW_ROUND = 18'h00003;
  localparam int DW_PER_ROW = 8;
  localparam int ROW_IDX_W = 6;
  localparam int ILEN_W = 17;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [7:0] {
    S_HDR = 8'h01,
    S_DESC = 8'h02,
    S_ILEN = 8'h04,
    S_ADDR = 8'h08,
    S_INL = 8'h10,
    S_FREQ = 8'h20,
    S_FDAT = 8'h40,
    S_FLUSH = 8'h80
  } phase_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [ILEN_W-1:0] len;
  } fetch_req_t;

  typedef struct packed {
    logic [ROW_IDX_W-1:0] idx;
    logic [DW_PER_ROW*32-1:0] data;
  } payload_row_t;
endpackage

// ---- core/row_packer.sv ----
// Packs dwords into 8-dword payload rows, zero filling a short last row
`timescale 1ns/10ps
`default_nettype none
module row_packer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Dword input
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  input wire logic clr,
  // Row output
  output logic out_valid,
  output payload_pkg::payload_row_t out_row,
  input wire logic out_ready,
  output logic idle
);
  typedef struct packed {
    logic [2:0] cnt;
    logic [payload_pkg::DW_PER_ROW*32-1:0] row;
    logic out_valid;
    logic [payload_pkg::ROW_IDX_W-1:0] idx;
  } pack_t;

  pack_t s_reg;
  pack_t s_next;

  // Row is held in place while offered, so filling stalls until it leaves
  assign in_ready = !s_reg.out_valid;
  assign out_valid = s_reg.out_valid;
  assign out_row = {s_reg.idx, s_reg.row};
  assign idle = !s_reg.out_valid && (s_reg.cnt == 3'h0);

  always_comb
  begin
    s_next = s_reg;
    if (in_valid && !s_reg.out_valid)
    begin
      s_next.row[{s_reg.cnt, 5'h00} +: 32] = in_data;
      if (s_reg.cnt == 3'h7 || in_last)
      begin
        s_next.out_valid = 1'b1;
        s_next.cnt = 3'h0;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 3'h1;
      end
    end
    if (s_reg.out_valid && out_ready)
    begin
      // Cleared row gives the zero padding of the next short row
      s_next.out_valid = 1'b0;
      s_next.row = '0;
      s_next.idx = s_reg.idx + 6'h01;
    end
    if (clr)
    begin
      s_next.idx = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ---- test/indirect_mem_model.sv ----
// Indirect memory responder: answers fetch requests with numbered dwords
`timescale 1ns/10ps
`default_nettype none
module indirect_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fetch request
  input wire logic fetch_valid,
  output logic fetch_ready,
  input wire payload_pkg::fetch_req_t fetch_req,
  // Indirect dwords
  output logic fdat_valid,
  input wire logic fdat_ready,
  output logic [31:0] fdat_data,
  // Pace select
  input wire logic slow
);
  logic [31:0] a;
  int n;
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fetch_ready = 1'b0;
    fdat_valid = 1'b0;
    fdat_data = 32'h0;
    forever
    begin
      @(posedge aclk);
      if (aresetn && fetch_valid && !fetch_ready)
      begin
        if (slow)
          repeat (3) @(posedge aclk);
        fetch_ready <= 1'b1;
        @(posedge aclk);
        fetch_ready <= 1'b0;
        // Dword j of the object sits at the fetched address plus j
        a = fetch_req.addr;
        n = (int'(fetch_req.len) + 3) / 4;
        for (int j = 0; j < n; j++)
        begin
          fdat_valid <= 1'b1;
          fdat_data <= a + 32'(j);
          do @(posedge aclk); while (!fdat_ready);
          if (slow)
          begin
            // Released data is inverted so a stale sample cannot match
            fdat_valid <= 1'b0;
            fdat_data <= ~(a + 32'(j));
            @(posedge aclk);
          end
        end
        fdat_valid <= 1'b0;
        fdat_data <= ~(a + 32'(n));
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/test_media_object_payload_assembler.sv ----
// Self-checking bench for the payload assembler
`timescale 1ns/10ps
`default_nettype none
module test_media_object_payload_assembler;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic cmd_valid = 1'b0, pay_ready = 1'b0, slow = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, cmd_data = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, cmd_ready, fetch_valid, fetch_ready;
  logic fdat_valid, fdat_ready, pay_valid, obj_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, fdat_data, first, exp_fa;
  logic [31:0] seed = 32'h11c7;
  logic [31:0] base_v = 32'h0004_0000;
  logic [16:0] exp_fl;
  payload_pkg::fetch_req_t fetch_req;
  payload_pkg::payload_row_t pay_row;
  logic [255:0] exp_q[$];
  int errors = 0, n_compared = 0, n_fetch = 0, row_i = 0;

  always #4 aclk = ~aclk;

  media_object_payload_assembler dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .cmd_valid, .cmd_ready, .cmd_data,
    .fetch_valid, .fetch_ready, .fetch_req, .fdat_valid, .fdat_ready, .fdat_data,
    .pay_valid, .pay_ready, .pay_row, .obj_done);
  indirect_mem_model mem (.aclk, .aresetn, .fetch_valid, .fetch_ready, .fetch_req,
    .fdat_valid, .fdat_ready, .fdat_data, .slow);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tmo();
    errors++;
    $display("unexpected wait expected handshake seen timeout");
    conclude();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Sink stalls at random when slow so rows must stand until taken
  always @(posedge aclk)
    pay_ready <= slow ? ((rnd() & 32'h3) == 32'h0) : 1'b1;

  always @(posedge aclk)
    if (aresetn && pay_valid && pay_ready)
    begin
      check("row idx", 256'(pay_row.idx), 256'(row_i));
      check("row data", pay_row.data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      row_i++;
    end

  always @(posedge aclk)
    if (aresetn && fetch_valid && fetch_ready)
    begin
      n_fetch++;
      check("fetch addr", 256'(fetch_req.addr), 256'(exp_fa));
      check("fetch len", 256'(fetch_req.len), 256'(exp_fl));
    end
  //////////////////////////////////////////////////////////////////////////////
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      r = bresp;
      if (bvalid)
        break;
    end
    if (k == 100)
      tmo();
    bready <= 1'b0;
    check("bresp", 256'(r), 256'(er));
    @(posedge aclk);
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er,
                     input logic [31:0] m);
    int k;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      d = rdata;
      r = rresp;
      if (rvalid)
        break;
    end
    if (k == 100)
      tmo();
    rready <= 1'b0;
    check("rdata", 256'(d & m), 256'(exp));
    check("rresp", 256'(r), 256'(er));
    @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmd(input int n, input logic [16:0] il, input logic [31:0] sa);
    logic [31:0] w[$];
    logic [255:0] row;
    int k, f0, ni, p;
    row = '0;
    row_i = 0;
    f0 = n_fetch;
    exp_fa = base_v + sa;
    exp_fl = il;
    ni = (int'(il) + 3) / 4;
    w = '{32'(n + 2), rnd(), {15'h0, il}, sa};
    for (k = 0; k < n + ni; k++)
    begin
      if (k < n)
        w.push_back(rnd());
      // Indirect dwords restart at slot 0 of a fresh row
      p = k < n ? k % 8 : (k - n) % 8;
      row[32 * p +: 32] = k < n ? w[k + 4] : exp_fa + 32'(k - n);
      // Inline and indirect each close their own zero padded row
      if (p == 7 || k == n - 1 || k == n + ni - 1)
      begin
        exp_q.push_back(row);
        row = '0;
      end
    end
    first = w[4];
    cmd_valid <= 1'b1;
    foreach (w[j])
    begin
      cmd_data <= w[j];
      for (k = 0; k < 2000; k++)
      begin
        @(posedge aclk);
        if (cmd_ready)
          break;
      end
      if (k == 2000)
        tmo();
    end
    cmd_valid <= 1'b0;
    for (k = 0; k < 2000 && !obj_done; k++)
      @(posedge aclk);
    if (k == 2000)
      tmo();
    check("rows left", 256'(exp_q.size()), 256'h0);
    check("fetches", 256'(n_fetch - f0), 256'(il != 17'h0));
    @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int nt[6] = '{1, 8, 9, 16, 7, 2};
    logic [16:0] ilt[6] = '{17'h0, 17'h20, 17'h24, 17'h0, 17'h4, 17'h40};
    logic [31:0] sat[6] = '{32'h8, 32'h40, 32'h83, 32'h0, 32'h100, 32'h5};
    logic [1:0] m;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(payload_pkg::REG_CTRL, 32'h0, payload_pkg::RESP_OKAY, '1);
    axr(payload_pkg::REG_BASE, 32'h0, payload_pkg::RESP_OKAY, '1);
    axr(12'h010, 32'h0, payload_pkg::RESP_SLVERR, '1);
    axw(12'h010, 32'h5, payload_pkg::RESP_SLVERR);
    axw(payload_pkg::REG_BASE, base_v, payload_pkg::RESP_OKAY);
    axr(payload_pkg::REG_BASE, base_v, payload_pkg::RESP_OKAY, '1);
    for (int i = 0; i < 6; i++)
    begin
      m = 2'(i % 3);
      slow <= i[0];
      axw(payload_pkg::REG_CTRL, {30'h0, m}, payload_pkg::RESP_OKAY);
      axr(payload_pkg::REG_CTRL, {30'h0, m}, payload_pkg::RESP_OKAY, '1);
      // Generic commands always carry inline data, addresses stay low
      cmd(nt[i], ilt[i], sat[i]);
      if (m == payload_pkg::MODE_INV_SCAN)
        axr(payload_pkg::REG_DECODE, {24'h0, first[31:24]}, 2'h0, '1);
      if (m == payload_pkg::MODE_BITSTREAM)
        axr(payload_pkg::REG_DECODE, first, payload_pkg::RESP_OKAY, '1);
    end
    axr(payload_pkg::REG_STATUS, 32'h0, payload_pkg::RESP_OKAY, 32'h6);
    axw(payload_pkg::REG_CTRL, 32'h0, payload_pkg::RESP_OKAY);
    cmd(1, 17'h8, 32'h2);
    axr(payload_pkg::REG_STATUS, 32'h2, payload_pkg::RESP_OKAY, 32'h6);
    axw(payload_pkg::REG_STATUS, 32'h2, payload_pkg::RESP_OKAY);
    axr(payload_pkg::REG_STATUS, 32'h0, payload_pkg::RESP_OKAY, 32'h6);
    cmd(1, 17'h8, 32'h2000_0004);
    axr(payload_pkg::REG_STATUS, 32'h4, payload_pkg::RESP_OKAY, 32'h6);
    conclude();
  end
endmodule
`default_nettype wire
